// *** rtl/mcad_pkg.sv ***
// mcad_pkg: types and constants of the core execution datapath
// assumes one 100 MHz clock
package mcad_pkg;

  // ********************
  // timing and sizes
  // ********************
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         SYS_PER_INST  = 4;
  localparam logic [1:0] PHASE_LAST    = 2'(SYS_PER_INST - 1);
  localparam int         PC_W          = 12;
  localparam int         STACK_DEPTH   = 8;
  localparam int         SP_W          = 3;
  localparam logic [1:0] SECTOR_ZERO   = 2'h0;
  localparam logic [7:0] PCL_MEM_ADDR  = 8'h06;

  // ********************
  // register map
  // ********************
  localparam logic [7:0] ADDR_ACCUM  = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PC     = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0C;
  localparam int         ST_FAULT    = 6;
  localparam int         CTRL_RUN    = 0;
  localparam logic       RUN_RST     = 1'b1;
  localparam logic [7:0] ACCUM_RST   = 8'h00;
  localparam logic [5:0] FLAGS_RST   = 6'h00;

  typedef enum logic [5:0] {
    op_nop, op_add, op_adc, add_to_memory_op, add_carry_to_memory_op,
    op_sub, subtract_to_memory_op, subtract_with_borrow_op,
    subtract_borrow_to_memory_op, decimal_adjust_op,
    op_and, op_or, op_xor, and_to_memory_op, or_to_memory_op, xor_to_memory_op,
    invert_op, invert_to_accumulator_op, op_inc, increment_to_accumulator_op,
    op_dec, decrement_to_accumulator_op,
    rotate_right_op, rotate_right_to_accumulator_op,
    rotate_right_through_carry_op, rotate_right_carry_to_accumulator_op,
    rotate_left_op, rotate_left_to_accumulator_op,
    rotate_left_through_carry_op, rotate_left_carry_to_accumulator_op,
    op_bit_set, op_bit_clear, op_skip_zero, op_skip_nonzero,
    op_skip_bit_zero, op_skip_bit_one, op_skip_inc_zero, op_skip_dec_zero,
    op_mov_to_mem, op_mov_to_accum, unconditional_branch_op, op_call,
    subroutine_return_op
  } mcad_op_type;

  typedef struct packed {
    logic chained_zero_flag;
    logic signed_compare_flag;
    logic overflow_flag;
    logic auxiliary_carry_flag;
    logic carry_flag;
    logic zero_flag;
  } mcad_flags_type;

  typedef struct packed {
    mcad_op_type       op;
    logic              use_imm;
    logic [1:0]        sector;
    logic [7:0]        addr;
    logic [7:0]        imm;
    logic [2:0]        bit_index;
    logic [PC_W-1:0]   target;
    logic [7:0]        mem_data;
  } mcad_inst_type;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } mcad_mem_wr_type;

endpackage : mcad_pkg

// *** rtl/mcad_alu.sv ***
// mcad_alu: combinational byte operations and flag computation
// assumes operands stable while taken
`timescale 1ns/10ps
`default_nettype none
module mcad_alu
  import mcad_pkg::*;
(
  input  wire mcad_op_type    op,
  input  wire logic [7:0]     a,
  input  wire logic [7:0]     m,
  input  wire logic [7:0]     imm,
  input  wire logic           use_imm,
  input  wire logic [2:0]     bit_index,
  input  wire mcad_flags_type flags_in,
  output mcad_flags_type      flags_out,
  output logic [7:0]          res,
  output logic                to_acc,
  output logic                to_mem,
  output logic                skip
);

  logic [7:0] b;
  logic [7:0] bx;
  logic [7:0] bmask;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [8:0] dadj;
  logic       arith;
  logic       sub;
  logic       cin;
  logic       chain;
  logic       zonly;

  always_comb begin
    b     = use_imm ? imm : m;
    bmask = 8'h01 << bit_index; // RULE18
    arith = 1'b0;
    sub   = 1'b0;
    cin   = 1'b0;
    chain = 1'b0;
    case (op)
      op_add, add_to_memory_op: arith = 1'b1;
      op_adc, add_carry_to_memory_op: begin
        arith = 1'b1;
        cin   = flags_in.carry_flag;
      end
      op_sub, subtract_to_memory_op: begin
        arith = 1'b1;
        sub   = 1'b1;
        cin   = 1'b1;
      end
      subtract_with_borrow_op, subtract_borrow_to_memory_op: begin
        arith = 1'b1;
        sub   = 1'b1;
        cin   = flags_in.carry_flag; // RULE5
        chain = 1'b1;
      end
      default: arith = 1'b0;
    endcase
    // one adder for both: subtract adds the inverse, carry set means no borrow
    bx  = sub ? ~b : b;
    sum = {1'b0, a} + {1'b0, bx} + {8'h00, cin}; // RULE1
    nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin}; // RULE25
    dadj = {1'b0, a};
    if (a[3:0] > 4'h9 || flags_in.auxiliary_carry_flag) begin
      dadj = dadj + 9'h006;
    end
    if (dadj[7:4] > 4'h9 || flags_in.carry_flag || dadj[8]) begin
      dadj = dadj + 9'h060;
    end
    res       = a;
    flags_out = flags_in;
    to_acc    = 1'b0;
    to_mem    = 1'b0;
    skip      = 1'b0;
    zonly     = 1'b1;
    case (op)
      op_add, op_adc, op_sub, subtract_with_borrow_op: to_acc = 1'b1; // RULE2 RULE4
      add_to_memory_op, add_carry_to_memory_op: to_mem = 1'b1; // RULE3
      subtract_to_memory_op, subtract_borrow_to_memory_op: to_mem = 1'b1; // RULE6
      decimal_adjust_op: begin
        res    = dadj[7:0];
        to_mem = 1'b1;
        zonly  = 1'b0;
        flags_out.carry_flag = flags_in.carry_flag | dadj[8]; // RULE7
      end
      op_and, op_or, op_xor: begin
        res    = op == op_and ? a & b : op == op_or ? a | b : a ^ b; // RULE8 RULE22
        to_acc = 1'b1;
      end
      and_to_memory_op, or_to_memory_op, xor_to_memory_op: begin
        res    = op == and_to_memory_op ? a & m : op == or_to_memory_op ? a | m : a ^ m; // RULE9
        to_mem = 1'b1;
      end
      invert_op, invert_to_accumulator_op: begin
        res    = ~m; // RULE11
        to_mem = op == invert_op;
        to_acc = op != invert_op;
      end
      op_inc, increment_to_accumulator_op: begin
        res    = m + 8'h01; // RULE12
        to_mem = op == op_inc;
        to_acc = op != op_inc;
      end
      op_dec, decrement_to_accumulator_op: begin
        res    = m - 8'h01; // RULE13
        to_mem = op == op_dec;
        to_acc = op != op_dec;
      end
      rotate_right_op, rotate_right_to_accumulator_op,
      rotate_left_op, rotate_left_to_accumulator_op: begin
        res    = (op == rotate_right_op || op == rotate_right_to_accumulator_op) ?
                 {m[0], m[7:1]} : {m[6:0], m[7]}; // RULE14
        to_mem = op == rotate_right_op || op == rotate_left_op;
        to_acc = !to_mem;
        zonly  = 1'b0;
      end
      rotate_right_through_carry_op, rotate_right_carry_to_accumulator_op: begin
        res    = {flags_in.carry_flag, m[7:1]}; // RULE15
        to_mem = op == rotate_right_through_carry_op;
        to_acc = !to_mem;
        zonly  = 1'b0;
        flags_out.carry_flag = m[0];
      end
      rotate_left_through_carry_op, rotate_left_carry_to_accumulator_op: begin
        res    = {m[6:0], flags_in.carry_flag}; // RULE16
        to_mem = op == rotate_left_through_carry_op;
        to_acc = !to_mem;
        zonly  = 1'b0;
        flags_out.carry_flag = m[7];
      end
      op_bit_set, op_bit_clear: begin
        res    = op == op_bit_set ? m | bmask : m & ~bmask; // RULE17
        to_mem = 1'b1;
        zonly  = 1'b0;
      end
      op_skip_zero, op_skip_nonzero, op_skip_bit_zero, op_skip_bit_one: begin
        zonly = 1'b0;
        case (op)
          op_skip_zero:     skip = m == 8'h00; // RULE19
          op_skip_nonzero:  skip = m != 8'h00;
          op_skip_bit_zero: skip = (m & bmask) == 8'h00;
          default:          skip = (m & bmask) != 8'h00;
        endcase
      end
      op_skip_inc_zero, op_skip_dec_zero: begin
        res    = op == op_skip_inc_zero ? m + 8'h01 : m - 8'h01;
        to_mem = 1'b1;
        zonly  = 1'b0;
        skip   = res == 8'h00; // RULE19
      end
      op_mov_to_mem: begin
        to_mem = 1'b1;
        zonly  = 1'b0;
      end
      op_mov_to_accum: begin
        res    = m;
        to_acc = 1'b1;
        zonly  = 1'b0;
      end
      default: zonly = 1'b0;
    endcase
    if (arith) begin
      res = sum[7:0];
      flags_out.carry_flag           = sum[8];
      flags_out.auxiliary_carry_flag = nib[4];
      flags_out.overflow_flag        = (a[7] == bx[7]) && (res[7] != a[7]);
      flags_out.zero_flag            = res == 8'h00;
      flags_out.signed_compare_flag  = res[7] ^ flags_out.overflow_flag;
      if (sub) begin
        flags_out.chained_zero_flag = (res == 8'h00) && (!chain || flags_in.chained_zero_flag);
      end
    end else if (zonly) begin
      flags_out.zero_flag = res == 8'h00; // RULE10
    end
  end

endmodule : mcad_alu
`default_nettype wire

// *** rtl/mcad_datapath.sv ***
// mcad_datapath: accumulator datapath with flags, program counter and apb access
// assumes the sequencer holds inst with its fetched memory byte while inst_valid
// Function
// RULE1: carry on sum above 255, borrow on below 0
// RULE2: add forms take one cycle, five flags
// RULE3: add-to-memory writes sum back to byte
// RULE4: subtract takes one cycle, six flags
// RULE5: borrow variants fold carry into difference
// RULE6: subtract-to-memory stores difference in byte
// RULE7: decimal adjust writes memory, changes carry only
// RULE8: logic ops to accumulator touch zero only
// RULE9: logic-to-memory writes byte, zero flag only
// RULE10: zero flag follows logic result equal zero
// RULE11: invert byte to memory or accumulator
// RULE12: increment by exactly one, zero flag only
// RULE13: decrement by exactly one, zero flag only
// RULE14: plain rotates circulate byte, no flags
// RULE15: right rotate through carry, carry only
// RULE16: left rotate through carry, carry only
// RULE17: bit set or clear keeps other bits
// RULE18: bit index limited to zero through seven
// RULE19: test skips next instruction on condition
// RULE20: call saves next address, return resumes it
// RULE21: short memory forms reach sector zero only
// RULE22: one operand always via the accumulator
// RULE23: program counter writes and taken skips take two
// RULE24: instruction cycle spans four system clocks
// RULE25: aux carry from bit three, signed overflow
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module mcad_datapath
  import mcad_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          inst_valid,
  input  wire mcad_inst_type inst,
  output logic               inst_ready,
  output mcad_mem_wr_type    mem_wr,
  output logic [PC_W-1:0]    pc_value
);

  // ********************
  // state
  // ********************
  logic [1:0]      phase_reg;
  logic            hold_reg;
  logic            run_reg;
  logic            fault_reg;
  logic [7:0]      accumulator_reg;
  mcad_flags_type  flags_reg;
  logic [PC_W-1:0] pc_reg;
  logic [SP_W-1:0] sp_reg;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  mcad_mem_wr_type mem_wr_reg;
  logic [31:0]     prdata_reg;

  logic            tick;
  logic            accept;
  logic            uses_mem;
  logic            refused;
  logic            effective;
  logic            branch;
  logic            pcl_write;
  logic            long_inst;
  logic            apb_wr;
  logic            mapped;
  mcad_flags_type  alu_flags;
  logic [7:0]      alu_res;
  logic            alu_to_acc;
  logic            alu_to_mem;
  logic            alu_skip;

  mcad_alu u_alu (
    .op        (inst.op),
    .a         (accumulator_reg),
    .m         (inst.mem_data),
    .imm       (inst.imm),
    .use_imm   (inst.use_imm),
    .bit_index (inst.bit_index),
    .flags_in  (flags_reg),
    .flags_out (alu_flags),
    .res       (alu_res),
    .to_acc    (alu_to_acc),
    .to_mem    (alu_to_mem),
    .skip      (alu_skip)
  );

  // ********************
  // instruction cycle timing
  // ********************
  // a slow enable, not a clock: every flop stays on pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1; // RULE24
    end
  end

  assign tick       = phase_reg == PHASE_LAST;
  assign inst_ready = tick && !hold_reg && run_reg;
  assign accept     = inst_valid && inst_ready;

  assign branch    = inst.op == unconditional_branch_op || inst.op == op_call ||
                     inst.op == subroutine_return_op;
  assign uses_mem  = !inst.use_imm && !branch && inst.op != op_nop;
  assign refused   = uses_mem && inst.sector != SECTOR_ZERO; // RULE21
  assign effective = accept && !refused;
  assign pcl_write = alu_to_mem && inst.addr == PCL_MEM_ADDR;
  assign long_inst = !refused && (branch || pcl_write || alu_skip); // RULE23

  // second instruction cycle blocks the next take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
    end else if (accept) begin
      hold_reg <= long_inst; // RULE23
    end else if (tick) begin
      hold_reg <= 1'b0;
    end
  end

  // ********************
  // accumulator and flags
  // ********************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator_reg <= ACCUM_RST;
    end else if (effective && alu_to_acc) begin
      accumulator_reg <= alu_res; // RULE22
    end else if (apb_wr && paddr == ADDR_ACCUM) begin
      accumulator_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= FLAGS_RST;
    end else if (effective) begin
      flags_reg <= alu_flags; // RULE2 RULE4
    end else if (apb_wr && paddr == ADDR_STATUS) begin
      flags_reg <= pwdata[5:0];
    end
  end

  // refused access is sticky; a new refusal beats the software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= 1'b0;
    end else if (accept && refused) begin
      fault_reg <= 1'b1; // RULE21
    end else if (apb_wr && paddr == ADDR_STATUS && pwdata[ST_FAULT]) begin
      fault_reg <= 1'b0;
    end
  end

  // ********************
  // data memory write port
  // ********************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wr_reg <= '0;
    end else begin
      mem_wr_reg.we   <= effective && alu_to_mem; // RULE3 RULE9
      mem_wr_reg.addr <= inst.addr;
      mem_wr_reg.data <= alu_res;
    end
  end

  assign mem_wr = mem_wr_reg;

  // ********************
  // program counter and return stack
  // ********************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= '0;
    end else if (effective) begin
      case (inst.op)
        unconditional_branch_op, op_call: pc_reg <= inst.target;
        subroutine_return_op: pc_reg <= stack_mem[sp_reg - 3'h1]; // RULE20
        default: begin
          if (pcl_write) begin
            pc_reg <= {pc_reg[PC_W-1:8], alu_res}; // RULE23
          end else if (alu_skip) begin
            pc_reg <= pc_reg + 12'h002; // RULE19
          end else begin
            pc_reg <= pc_reg + 12'h001;
          end
        end
      endcase
    end else if (accept) begin
      pc_reg <= pc_reg + 12'h001;
    end
  end

  // overflow wraps silently, like a small hardware stack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= '0;
    end else if (effective && inst.op == op_call) begin
      sp_reg <= sp_reg + 3'h1;
    end else if (effective && inst.op == subroutine_return_op) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (effective && inst.op == op_call) begin
      stack_mem[sp_reg] <= pc_reg + 12'h001; // RULE20
    end
  end

  assign pc_value = pc_reg;

  // ********************
  // apb slave
  // ********************
  assign apb_wr  = psel && penable && pwrite;
  assign mapped  = paddr == ADDR_ACCUM || paddr == ADDR_STATUS ||
                   paddr == ADDR_PC || paddr == ADDR_CTRL;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= RUN_RST;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      run_reg <= pwdata[CTRL_RUN];
    end
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == ADDR_ACCUM) begin
        prdata_reg <= {24'h000000, accumulator_reg};
      end else if (paddr == ADDR_STATUS) begin
        prdata_reg <= {25'h0000000, fault_reg, flags_reg};
      end else if (paddr == ADDR_PC) begin
        prdata_reg <= {20'h00000, pc_reg};
      end else if (paddr == ADDR_CTRL) begin
        prdata_reg <= {31'h00000000, run_reg};
      end else begin
        prdata_reg <= '0;
      end
    end
  end

  assign prdata = prdata_reg;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_short_take;
    accept && !long_inst;
  endsequence

  sequence s_long_take;
    accept && long_inst;
  endsequence

  sequence s_call_take;
    effective && inst.op == op_call;
  endsequence

  a_tick_period: assert property (tick |=> !tick [*3] ##1 tick) // RULE24
    else $error("instruction tick not every four clocks");

  a_short_cycle: assert property (s_short_take |-> ##4 (tick && !hold_reg)) // RULE2
    else $error("single cycle instruction held too long");

  a_long_cycle: assert property (s_long_take |-> ##4 (tick && hold_reg) ##4 (tick && !hold_reg)) // RULE23
    else $error("two cycle instruction timing wrong");

  a_add_carry: assert property (effective && inst.op == op_add &&
    ({1'b0, accumulator_reg} + {1'b0, (inst.use_imm ? inst.imm : inst.mem_data)}) > 9'h0FF
    |=> flags_reg.carry_flag) // RULE1
    else $error("carry not set on add above 255");

  a_logic_zero: assert property (effective && inst.op inside {op_and, op_or, op_xor}
    |=> flags_reg.zero_flag == (accumulator_reg == 8'h00) && $stable(flags_reg.carry_flag)) // RULE10
    else $error("logic op zero flag wrong");

  a_rotate_noflag: assert property (effective && inst.op inside {rotate_right_op, rotate_left_op}
    |=> $stable(flags_reg) && mem_wr.we) // RULE14
    else $error("plain rotate changed flags");

  a_bit_only: assert property (effective && inst.op == op_bit_set
    |=> mem_wr.data == ($past(inst.mem_data) | (8'h01 << $past(inst.bit_index)))) // RULE17
    else $error("bit set altered other bits");

  a_inc_exact: assert property (effective && inst.op == increment_to_accumulator_op
    |=> accumulator_reg == $past(inst.mem_data) + 8'h01) // RULE12
    else $error("increment not by one");

  a_sector_guard: assert property (mem_wr.we |-> $past(inst.sector) == SECTOR_ZERO) // RULE21
    else $error("memory write outside sector zero");

  a_call_return: assert property (s_call_take |=> stack_mem[sp_reg - 3'h1] == $past(pc_reg) + 12'h001) // RULE20
    else $error("call saved wrong return address");

endmodule : mcad_datapath
`default_nettype wire

// *** tb/mcad_mem_model.sv ***
// mcad_mem_model: data memory sector 0 standing behind the datapath
// assumes one-cycle write pulses
`timescale 1ns/10ps
`default_nettype none
module mcad_mem_model
  import mcad_pkg::*;
(
  input  wire logic            pclk,
  input  wire mcad_mem_wr_type mem_wr,
  input  wire logic [7:0]      rd_addr,
  output logic [7:0]           rd_data
);
  logic [7:0] mem [256];

  assign rd_data = mem[rd_addr];

  always @(posedge pclk) begin
    if (mem_wr.we) begin
      mem[mem_wr.addr] <= mem_wr.data;
    end
  end
endmodule : mcad_mem_model
`default_nettype wire

// *** tb/mcad_datapath_tb.sv ***
// mcad_datapath_tb: random and corner op sweep
// assumes the bench plays the sequencer
`timescale 1ns/10ps
`default_nettype none
module mcad_datapath_tb;
  import mcad_pkg::*;
  logic            pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic            inst_valid = 1'b0, pready, pslverr, inst_ready, errv;
  logic [7:0]      paddr = 8'h00, rd_data;
  logic [31:0]     pwdata = 32'h0, prdata, rdv;
  logic [PC_W-1:0] pc_value, pc0;
  mcad_inst_type   inst_q = '0, inst;
  mcad_mem_wr_type mem_wr;
  int              err_total = 0, n_checks = 0, gap;
  logic [7:0]      ca [4] = '{8'hFF, 8'h00, 8'h7F, 8'h80};
  logic [7:0]      cm [4] = '{8'h01, 8'h01, 8'hFF, 8'h01};
  logic [5:0]      cf [4] = '{6'h00, 6'h3F, 6'h02, 6'h20};

  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  always_comb begin
    inst = inst_q;
    inst.mem_data = rd_data;
  end

  mcad_datapath mcad_datapath_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .inst_valid, .inst, .inst_ready, .mem_wr, .pc_value);
  mcad_mem_model mcad_mem_model_i (.pclk, .mem_wr, .rd_addr(inst_q.addr), .rd_data);

  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_val

  task automatic chk_cnt(input int g, input int e, input string m);
    n_checks++;
    if (g != e) begin
      err_total++;
      $display("FAIL %0t %s cycles %0d exp %0d", $time, m, g, e);
    end
  endtask : chk_cnt

  // ********************
  // bus and sequencer
  // ********************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // gap: edges from take to next offer
  task automatic issue(input mcad_op_type op, input logic ui, input logic [1:0] sec,
                       input logic [7:0] ad, input logic [7:0] im, input logic [2:0] bi, input logic [11:0] tg);
    int n;
    repeat ($urandom_range(0, 3)) @(posedge pclk);
    inst_q <= '{op: op, use_imm: ui, sector: sec, addr: ad, imm: im, bit_index: bi, target: tg, mem_data: 8'h00};
    inst_valid <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (inst_ready !== 1'b1 && n < 50);
    inst_valid <= 1'b0;
    gap = 0;
    do begin @(posedge pclk); gap++; end while (inst_ready !== 1'b1 && gap < 50);
  endtask : issue

  function automatic void calc(input mcad_op_type op, input logic [7:0] a, input logic [7:0] b,
                               input mcad_flags_type f, input logic [2:0] bi,
                               output logic [7:0] r, output mcad_flags_type o);
    logic [8:0] s;
    logic [4:0] h;
    logic       ci, ar, sb;
    o = f; r = b; ar = 1'b0; s = '0; h = '0;
    case (op)
      op_add, op_adc, add_to_memory_op, add_carry_to_memory_op: begin
        ci = (op == op_adc || op == add_carry_to_memory_op) & f.carry_flag;
        s = a + b + ci; h = a[3:0] + b[3:0] + ci; ar = 1'b1;
        o.carry_flag = s[8]; o.auxiliary_carry_flag = h[4];
        o.overflow_flag = a[7] == b[7] && s[7] != a[7];
      end
      op_sub, subtract_to_memory_op, subtract_with_borrow_op, subtract_borrow_to_memory_op: begin
        sb = op == subtract_with_borrow_op || op == subtract_borrow_to_memory_op;
        ci = sb & !f.carry_flag;
        s = {1'b0, a} - b - ci; h = {1'b0, a[3:0]} - b[3:0] - ci; ar = 1'b1;
        o.carry_flag = !s[8]; o.auxiliary_carry_flag = !h[4];
        o.overflow_flag = a[7] != b[7] && s[7] != a[7];
        o.chained_zero_flag = s[7:0] == 8'h00 && (!sb || f.chained_zero_flag);
      end
      decimal_adjust_op: begin
        s = a + (a[3:0] > 4'h9 || f.auxiliary_carry_flag ? 9'h006 : 9'h000);
        s += s[7:4] > 4'h9 || f.carry_flag || s[8] ? 9'h060 : 9'h000;
        {o.carry_flag, r} = {f.carry_flag | s[8], s[7:0]};
      end
      op_and, and_to_memory_op: r = a & b;
      op_or, or_to_memory_op: r = a | b;
      op_xor, xor_to_memory_op: r = a ^ b;
      invert_op, invert_to_accumulator_op: r = ~b;
      op_inc, increment_to_accumulator_op: r = b + 8'h01;
      op_dec, decrement_to_accumulator_op: r = b - 8'h01;
      rotate_right_op, rotate_right_to_accumulator_op: r = {b[0], b[7:1]};
      rotate_left_op, rotate_left_to_accumulator_op: r = {b[6:0], b[7]};
      rotate_right_through_carry_op, rotate_right_carry_to_accumulator_op: {r, o.carry_flag} = {f.carry_flag, b};
      rotate_left_through_carry_op, rotate_left_carry_to_accumulator_op: {o.carry_flag, r} = {b, f.carry_flag};
      op_bit_set: r = b | (8'h01 << bi);
      default: r = b & ~(8'h01 << bi);
    endcase
    if (ar) begin
      r = s[7:0];
      o.signed_compare_flag = r[7] ^ o.overflow_flag;
    end
    if (op >= op_add && op <= decrement_to_accumulator_op && op != decimal_adjust_op) o.zero_flag = r == 8'h00;
  endfunction : calc

  task automatic run_one(input mcad_op_type op, input logic [7:0] a, input logic [7:0] m, input logic [5:0] f);
    logic [7:0]     ad, im, er;
    logic [2:0]     bi;
    logic           ui, ea;
    mcad_flags_type ef;
    ad = 8'($urandom_range(16, 255)); im = 8'($urandom); bi = 3'($urandom);
    ui = (op inside {op_add, op_sub, subtract_with_borrow_op, op_and, op_or, op_xor}) && $urandom_range(0, 1);
    ea = op inside {op_add, op_adc, op_sub, subtract_with_borrow_op, op_and, op_or, op_xor,
      invert_to_accumulator_op, increment_to_accumulator_op, decrement_to_accumulator_op,
      rotate_right_to_accumulator_op, rotate_right_carry_to_accumulator_op,
      rotate_left_to_accumulator_op, rotate_left_carry_to_accumulator_op};
    apb(1'b1, ADDR_ACCUM, {24'h0, a});
    apb(1'b1, ADDR_STATUS, {26'h0, f});
    mcad_mem_model_i.mem[ad] = m;
    calc(op, a, ui ? im : m, mcad_flags_type'(f), bi, er, ef);
    issue(op, ui, SECTOR_ZERO, ad, im, bi, 12'h000);
    chk_cnt(gap, SYS_PER_INST, "op");
    apb(1'b0, ADDR_ACCUM, 32'h0);
    chk_val(rdv, {24'h0, ea ? er : a}, "accum");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk_val(rdv, {26'h0, ef}, "flags");
    chk_val({24'h0, mcad_mem_model_i.mem[ad]}, {24'h0, ea ? m : er}, "mem");
  endtask : run_one

  // ********************
  // main sequence
  // ********************
  mcad_op_type sk [4] = '{op_skip_zero, op_skip_nonzero, op_skip_bit_one, op_skip_bit_zero};
  mcad_op_type bo [3] = '{unconditional_branch_op, op_call, subroutine_return_op};
  logic [11:0] be [3] = '{12'h123, 12'h200, 12'h123};
  initial begin
    void'($urandom(32'hD164));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk_val(rdv, 32'h1, "ctrl reset");
    apb(1'b0, 8'h10, 32'h0);
    chk_val({31'h0, errv}, 32'h1, "unmapped");
    // four corner passes, then random
    for (int p = 0; p < 8; p++) begin
      for (int k = int'(op_add); k <= int'(op_bit_clear); k++) begin
        run_one(mcad_op_type'(k), p < 4 ? ca[p] : 8'($urandom), p < 4 ? cm[p] : 8'($urandom),
                p < 4 ? cf[p] : 6'($urandom));
      end
    end
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_ACCUM, 32'h5A);
    pc0 = pc_value;
    issue(op_add, 1'b0, 2'h1, 8'h20, 8'h00, 3'h0, 12'h000);
    chk_val({20'h0, pc_value}, {20'h0, 12'(pc0 + 12'h001)}, "fault pc");
    apb(1'b0, ADDR_ACCUM, 32'h0);
    chk_val(rdv, 32'h5A, "fault accum");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk_val(rdv, 32'h40, "fault flag");
    for (int k = 0; k < 4; k++) begin
      mcad_mem_model_i.mem[8'h30] = k < 2 ? 8'h00 : 8'h08;
      pc0 = pc_value;
      issue(sk[k], 1'b0, SECTOR_ZERO, 8'h30, 8'h00, 3'h3, 12'h000);
      chk_cnt(gap, k % 2 ? 4 : 8, "skip");
      chk_val({20'h0, pc_value}, {20'h0, 12'(pc0 + (k % 2 ? 12'h001 : 12'h002))}, "skip pc");
    end
    for (int k = 0; k < 3; k++) begin
      issue(bo[k], 1'b0, SECTOR_ZERO, 8'h00, 8'h00, 3'h0, be[k] - 12'h001);
      chk_cnt(gap, 8, "branch");
      chk_val({20'h0, pc_value}, {20'h0, be[k] - 12'h001 + 12'(k == 2)}, "branch pc");
    end
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end
endmodule : mcad_datapath_tb
`default_nettype wire
